//--- asr_defs.svh
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// clock and times in their own units
`define ASR_CLK_HZ 25000000
`define ASR_DEBOUNCE_MS 1
`define ASR_MIN_PULSE_MS 12
`define ASR_COMM_ERR_MS 4000
`define ASR_OFF_EXTRA_MS 1000
`define ASR_KEY_WIN_MS 3000
`define ASR_SETTLE_CYC 4

// terminal function codes and source setting
`define ASR_FN_ANALOG_SEL 5'h10
`define ASR_FN_RESET 5'h12
`define ASR_SRC_ANALOG 2'h1

// register byte offsets
`define ASR_OFF_CTRL 5'h00
`define ASR_OFF_ASSIGN 5'h04
`define ASR_OFF_DIGREF 5'h08
`define ASR_OFF_STATUS 5'h0C
`define ASR_OFF_IRQSTAT 5'h10
`define ASR_OFF_IRQMASK 5'h14
`define ASR_OFF_FREQ 5'h18

// control fields and reset values
`define ASR_CTRL_SRC 1:0
`define ASR_CTRL_NC 6:2
`define ASR_CTRL_DLY 9:7
`define ASR_NC_LSB 2
`define ASR_DLY_LSB 7
`define ASR_FN_W 5
`define ASR_CTRL_RST 10'h001
`define ASR_ASSIGN_RST 25'h1FFFFF2
`define ASR_DIGREF_RST 11'h000

// interrupt bit positions
`define ASR_IRQ_TRIP 0
`define ASR_IRQ_RESET 1
`define ASR_IRQ_COMM 2
`endif

//--- asr_pkg.sv
package asr_pkg;
	// reset sequencer states, gray along idle-hold-apply
	typedef enum logic [1:0] {
		ASR_IDLE = 2'b00,
		ASR_HOLD = 2'b01,
		ASR_APPLY = 2'b11
	} asr_rst_e;
	// analog sample
	typedef logic [9:0] asr_ain_t;
endpackage : asr_pkg

//--- asr_analog_reset.sv
// The Avalon-MM register port and the placing of the registers were decided locally.
`include "asr_defs.svh"

module asr_analog_reset import asr_pkg::*; #(
	parameter int unsigned DEB_CYC = `ASR_DEBOUNCE_MS * (`ASR_CLK_HZ / 1000),
	parameter int unsigned PULSE_CYC = `ASR_MIN_PULSE_MS * (`ASR_CLK_HZ / 1000),
	parameter int unsigned COMM_CYC = `ASR_COMM_ERR_MS * (`ASR_CLK_HZ / 1000),
	parameter int unsigned OFFDLY_CYC = `ASR_OFF_EXTRA_MS * (`ASR_CLK_HZ / 1000),
	parameter int unsigned KEYWIN_CYC = `ASR_KEY_WIN_MS * (`ASR_CLK_HZ / 1000)
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// terminal and keypad pins
	input wire logic [4:0] termIn,
	input wire logic keyStopPin,
	input wire logic remoteConnPin,
	// drive logic on this clock
	input wire logic runCmd,
	input wire logic faultEvt,
	input wire logic [2:0] logicReq,
	input wire asr_ain_t voltageIn,
	input wire asr_ain_t currentIn,
	// drive outputs
	output logic motorEn,
	output logic [2:0] logicOut,
	output logic alarmOut,
	output logic pwrResetOut,
	output logic remoteCommErr,
	output logic [10:0] freqRef,
	output logic irq
);

	localparam int NPIN = 7; // five terminals, key, remote
	localparam int KEYB = 5; // key bit in pin vector
	localparam int REMB = 6; // remote bit in pin vector

	logic [NPIN-1:0] pinMeta_reg; // first sync stage
	logic [NPIN-1:0] pinSync_reg; // second sync stage
	logic [NPIN-1:0] pinDeb_reg; // debounced levels
	logic keyPrev_reg; // key level last cycle
	logic [9:0] ctrl_reg; // source, polarity, delay flags
	logic [24:0] assign_reg; // five 5-bit function codes
	logic [10:0] digRef_reg; // non-analog reference
	logic [2:0] irqStat_reg; // sticky events
	logic [2:0] irqMask_reg; // event enables
	logic waitReq_reg; // bus stall
	logic [31:0] rdData_reg; // bus read data
	asr_rst_e state_reg; // reset sequencer
	logic [31:0] holdCnt_reg; // reset active time
	logic [31:0] upCnt_reg; // time since power-up
	logic bootHold_reg; // reset held since power-up
	logic trip_reg; // trip mode
	logic alarm_reg; // alarm output
	logic motor_reg; // motor drive
	logic pwrReset_reg; // power-up reset applied
	logic commErr_reg; // remote comm error
	logic [10:0] freq_reg; // frequency reference
	logic [2:0] lout_reg; // logic outputs
	logic irq_reg; // interrupt line
	logic rsAct; // reset function active
	logic atAct; // analog select active
	logic atAssigned; // analog select on some terminal
	logic keyEdge; // key pressed this cycle
	logic keyOk; // key press allowed
	logic busTake; // request accepted this edge
	logic [2:0] irqSet; // events this cycle
	logic commSet; // comm error about to rise

	// outputs straight from flops
	assign avs_readdata = rdData_reg;
	assign avs_waitrequest = waitReq_reg;
	assign motorEn = motor_reg;
	assign logicOut = lout_reg;
	assign alarmOut = alarm_reg;
	assign pwrResetOut = pwrReset_reg;
	assign remoteCommErr = commErr_reg;
	assign freqRef = freq_reg;
	assign irq = irq_reg;

	// two-stage sync of all pins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
		end else begin
			pinMeta_reg <= {remoteConnPin, keyStopPin, termIn};
			pinSync_reg <= pinMeta_reg;
		end
	end

	// debounce: level taken once stable for the filter time
	for (genvar i = 0; i < NPIN; i++) begin : g_deb
		logic [31:0] debCnt_reg; // stability count
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				debCnt_reg <= '0;
				pinDeb_reg[i] <= 1'b0;
			end else if (pinSync_reg[i] == pinDeb_reg[i]) begin
				debCnt_reg <= '0; // no change pending
			end else if (debCnt_reg >= DEB_CYC) begin
				pinDeb_reg[i] <= pinSync_reg[i];
				debCnt_reg <= '0;
			end else begin
				debCnt_reg <= debCnt_reg + 32'h1;
			end
		end
	end

	// terminal function decode, polarity on analog select only
	always_comb begin
		rsAct = 1'b0;
		atAct = 1'b0;
		atAssigned = 1'b0;
		for (int t = 0; t < 5; t++) begin
			if (assign_reg[`ASR_FN_W*t +: `ASR_FN_W] == `ASR_FN_RESET) begin
				rsAct = rsAct | pinDeb_reg[t];
			end
			if (assign_reg[`ASR_FN_W*t +: `ASR_FN_W] == `ASR_FN_ANALOG_SEL) begin
				atAssigned = 1'b1;
				atAct = atAct | (pinDeb_reg[t] ^ ctrl_reg[`ASR_NC_LSB + t]);
			end
		end
	end

	// key press qualification
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			keyPrev_reg <= 1'b0;
		end else begin
			keyPrev_reg <= pinDeb_reg[KEYB];
		end
	end
	assign keyEdge = pinDeb_reg[KEYB] & ~keyPrev_reg;
	// remote panel limits key to window after power-up
	assign keyOk = keyEdge & alarm_reg & (~pinDeb_reg[REMB] | (upCnt_reg < KEYWIN_CYC));

	// time since power-up, saturating
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			upCnt_reg <= '0;
		end else if (upCnt_reg != 32'hFFFFFFFF) begin
			upCnt_reg <= upCnt_reg + 32'h1;
		end
	end

	// reset sequencer, starts in apply after power-on
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ASR_APPLY;
			holdCnt_reg <= '0;
		end else begin
			unique case (state_reg)
				ASR_IDLE: begin
					holdCnt_reg <= '0;
					if (rsAct) begin
						state_reg <= ASR_HOLD;
					end else if (keyOk) begin
						state_reg <= ASR_APPLY;
					end
				end
				ASR_HOLD: begin
					if (holdCnt_reg != 32'hFFFFFFFF) begin
						holdCnt_reg <= holdCnt_reg + 32'h1;
					end
					if (!rsAct) begin
						// release counts only after the minimum width
						state_reg <= (holdCnt_reg >= PULSE_CYC) ? ASR_APPLY : ASR_IDLE;
					end
				end
				ASR_APPLY: begin
					state_reg <= ASR_IDLE;
				end
			endcase
		end
	end

	// trip: fault sets, reset clears, set wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			trip_reg <= 1'b0;
		end else if (faultEvt) begin
			trip_reg <= 1'b1;
		end else if (rsAct || state_reg == ASR_APPLY) begin
			trip_reg <= 1'b0;
		end
	end

	// alarm follows trip
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alarm_reg <= 1'b0;
		end else begin
			alarm_reg <= trip_reg & ~rsAct;
		end
	end

	// motor drive cut at once, restarts if run still on
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			motor_reg <= 1'b0;
		end else begin
			motor_reg <= runCmd & ~trip_reg & ~rsAct & (state_reg != ASR_APPLY);
		end
	end

	// power-up reset while active and on the pulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pwrReset_reg <= 1'b1;
		end else begin
			pwrReset_reg <= rsAct | (state_reg == ASR_APPLY);
		end
	end

	// reset held since power-up: comm error after long hold
	assign commSet = bootHold_reg & rsAct & (state_reg == ASR_HOLD) & (holdCnt_reg >= COMM_CYC);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bootHold_reg <= 1'b1;
			commErr_reg <= 1'b0;
		end else begin
			if (!rsAct && upCnt_reg > DEB_CYC + `ASR_SETTLE_CYC) begin
				bootHold_reg <= 1'b0;
			end
			commErr_reg <= commSet;
		end
	end

	// logic outputs, optional extra on-time under reset
	for (genvar j = 0; j < 3; j++) begin : g_lout
		logic [31:0] offCnt_reg; // extra on-time
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				offCnt_reg <= '0;
				lout_reg[j] <= 1'b0;
			end else if (!rsAct) begin
				lout_reg[j] <= logicReq[j];
				offCnt_reg <= '0;
			end else if (ctrl_reg[`ASR_DLY_LSB + j] && lout_reg[j] && offCnt_reg < OFFDLY_CYC) begin
				offCnt_reg <= offCnt_reg + 32'h1;
			end else begin
				lout_reg[j] <= 1'b0;
			end
		end
	end

	// frequency reference selection
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			freq_reg <= '0;
		end else if (ctrl_reg[`ASR_CTRL_SRC] != `ASR_SRC_ANALOG) begin
			freq_reg <= digRef_reg;
		end else if (!atAssigned) begin
			freq_reg <= {1'b0, voltageIn} + {1'b0, currentIn};
		end else if (atAct) begin
			freq_reg <= {1'b0, currentIn};
		end else begin
			freq_reg <= {1'b0, voltageIn};
		end
	end

	// bus: one stall cycle then answer
	assign busTake = (avs_read | avs_write) & ~waitReq_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			waitReq_reg <= 1'b1;
			rdData_reg <= '0;
		end else if (!waitReq_reg) begin
			waitReq_reg <= 1'b1;
		end else if (avs_read || avs_write) begin
			waitReq_reg <= 1'b0;
			rdData_reg <= '0; // unmapped reads zero
			if (avs_read) begin
				unique case (avs_address)
					`ASR_OFF_CTRL: rdData_reg <= {22'h000000, ctrl_reg};
					`ASR_OFF_ASSIGN: rdData_reg <= {7'h00, assign_reg};
					`ASR_OFF_DIGREF: rdData_reg <= {21'h000000, digRef_reg};
					`ASR_OFF_STATUS: rdData_reg <= {24'h000000, state_reg, commErr_reg, alarm_reg,
						trip_reg, atAct, rsAct, motor_reg};
					`ASR_OFF_IRQSTAT: rdData_reg <= {29'h00000000, irqStat_reg};
					`ASR_OFF_IRQMASK: rdData_reg <= {29'h00000000, irqMask_reg};
					`ASR_OFF_FREQ: rdData_reg <= {21'h000000, freq_reg};
					default: rdData_reg <= '0;
				endcase
			end
		end
	end

	// writable configuration
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= `ASR_CTRL_RST;
			assign_reg <= `ASR_ASSIGN_RST;
			digRef_reg <= `ASR_DIGREF_RST;
			irqMask_reg <= '0;
		end else if (busTake && avs_write) begin
			unique case (avs_address)
				`ASR_OFF_CTRL: ctrl_reg <= avs_writedata[9:0];
				`ASR_OFF_ASSIGN: assign_reg <= avs_writedata[24:0];
				`ASR_OFF_DIGREF: digRef_reg <= avs_writedata[10:0];
				`ASR_OFF_IRQMASK: irqMask_reg <= avs_writedata[2:0];
				default: ;
			endcase
		end
	end

	// sticky events, write one clears, set wins
	assign irqSet[`ASR_IRQ_TRIP] = faultEvt & ~trip_reg;
	assign irqSet[`ASR_IRQ_RESET] = state_reg == ASR_APPLY;
	assign irqSet[`ASR_IRQ_COMM] = commSet & ~commErr_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqStat_reg <= '0;
		end else if (busTake && avs_write && avs_address == `ASR_OFF_IRQSTAT) begin
			irqStat_reg <= (irqStat_reg & ~avs_writedata[2:0]) | irqSet;
		end else begin
			irqStat_reg <= irqStat_reg | irqSet;
		end
	end

	// level interrupt
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irqStat_reg & irqMask_reg);
		end
	end

	// checks
	a_freq_current: assert property (@(posedge clk) disable iff (!nrst)
		(ctrl_reg[`ASR_CTRL_SRC] == `ASR_SRC_ANALOG && atAssigned && atAct)
		|=> freq_reg == {1'b0, $past(currentIn)})
		else $error("current input not selected");
	a_freq_voltage: assert property (@(posedge clk) disable iff (!nrst)
		(ctrl_reg[`ASR_CTRL_SRC] == `ASR_SRC_ANALOG && atAssigned && !atAct)
		|=> freq_reg == {1'b0, $past(voltageIn)})
		else $error("voltage input not selected");
	a_freq_digital: assert property (@(posedge clk) disable iff (!nrst)
		(ctrl_reg[`ASR_CTRL_SRC] != `ASR_SRC_ANALOG) |=> freq_reg == $past(digRef_reg))
		else $error("analog used with other source");
	a_freq_sum: assert property (@(posedge clk) disable iff (!nrst)
		(ctrl_reg[`ASR_CTRL_SRC] == `ASR_SRC_ANALOG && !atAssigned)
		|=> freq_reg == {1'b0, $past(voltageIn)} + {1'b0, $past(currentIn)})
		else $error("sum of inputs wrong");
	a_short_pulse: assert property (@(posedge clk) disable iff (!nrst)
		(state_reg == ASR_HOLD && !rsAct && holdCnt_reg < PULSE_CYC) |=> state_reg == ASR_IDLE)
		else $error("short pulse caused reset");
	a_alarm_clear: assert property (@(posedge clk) disable iff (!nrst)
		(rsAct && !faultEvt) [*2] |=> !alarm_reg)
		else $error("alarm not cleared");
	a_motor_coast: assert property (@(posedge clk) disable iff (!nrst)
		rsAct |=> !motor_reg && pwrReset_reg)
		else $error("motor driven under reset");
	a_key_gate: assert property (@(posedge clk) disable iff (!nrst)
		(state_reg == ASR_IDLE && !rsAct && !alarm_reg) |=> state_reg != ASR_APPLY)
		else $error("key reset without alarm");
	a_out_together: assert property (@(posedge clk) disable iff (!nrst)
		(rsAct && ctrl_reg[`ASR_CTRL_DLY] == 3'h0) |=> lout_reg == 3'h0)
		else $error("output not off at once");
	a_comm_release: assert property (@(posedge clk) disable iff (!nrst)
		(commErr_reg && !rsAct) |=> ##1 !commErr_reg)
		else $error("comm error not cleared");

endmodule : asr_analog_reset

//--- asr_contact_model.sv
module asr_contact_model (
	// clock
	input wire logic clk,
	// contacts toward the block
	output logic [4:0] termIn,
	output logic keyStopPin,
	output logic remoteConnPin
);
	timeunit 1ns;
	timeprecision 1ns;

	// closed contacts: terminals 0..4, stop key 5, remote plug 6
	logic [6:0] closedReg = 7'h00;

	// an open contact reads low through its pull-down
	assign termIn = closedReg[4:0];
	assign keyStopPin = closedReg[5];
	assign remoteConnPin = closedReg[6];

	// steady level on one contact from the next edge
	task automatic set(input int t, input logic v);
		@(posedge clk);
		closedReg[t] <= v;
	endtask : set

	// bouncing closure, held for n clocks, then opened
	task automatic hold(input int t, input int n);
		@(posedge clk);
		closedReg[t] <= 1'b1;
		@(posedge clk);
		closedReg[t] <= 1'b0;
		@(posedge clk);
		closedReg[t] <= 1'b1;
		// the caller picks n, at least the minimum width unless it means to break it
		repeat (n) @(posedge clk);
		closedReg[t] <= 1'b0;
	endtask : hold
endmodule : asr_contact_model

//--- tb_top.sv
`define CHK(g, e) check(32'(g), 32'(e))

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import asr_pkg::*;

	// clock, reset and bus
	logic clk, avs_waitrequest;
	logic nrst = 1'b0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	// contacts and drive side
	logic [4:0] termIn;
	logic keyStopPin, remoteConnPin;
	logic runCmd = 1'b0;
	logic faultEvt = 1'b0;
	logic [2:0] logicReq = 3'h0;
	asr_ain_t voltageIn = 10'h000;
	asr_ain_t currentIn = 10'h000;
	logic motorEn, alarmOut, pwrResetOut, remoteCommErr, irq;
	logic [2:0] logicOut;
	logic [10:0] freqRef, digRef;
	// expected read data, oldest first
	logic [31:0] expQ[$];
	// power-on register table
	logic [4:0] regA[7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h1C};
	logic [31:0] regE[7] = '{32'h1, 32'h1FFFFF2, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0};
	// counters
	int errTotal = 0;
	int numChecks = 0;
	int cycCount = 0;

	// block under test, long counts shortened
	asr_analog_reset #(.DEB_CYC(4), .PULSE_CYC(20), .COMM_CYC(60), .OFFDLY_CYC(10), .KEYWIN_CYC(100)) dut_u (
		.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.termIn(termIn), .keyStopPin(keyStopPin), .remoteConnPin(remoteConnPin), .runCmd(runCmd),
		.faultEvt(faultEvt), .logicReq(logicReq), .voltageIn(voltageIn), .currentIn(currentIn),
		.motorEn(motorEn), .logicOut(logicOut), .alarmOut(alarmOut), .pwrResetOut(pwrResetOut),
		.remoteCommErr(remoteCommErr), .freqRef(freqRef), .irq(irq));

	// contacts, keypad and remote plug
	asr_contact_model mdl (.clk(clk), .termIn(termIn), .keyStopPin(keyStopPin), .remoteConnPin(remoteConnPin));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// one comparison, counted
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		numChecks++;
		if (g !== e) begin
			errTotal++;
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
		end
	endtask : check

	// verdict and end of run
	task automatic summarize();
		$display("checks %0d, errors %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	// hang guard
	always @(posedge clk) begin
		cycCount++;
		if (cycCount == 4000) begin
			errTotal++;
			summarize();
		end
	end

	// each answered read is compared with the oldest note
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			`CHK(avs_readdata, expQ.pop_front());
		end
	end

	// one bus access; a read notes its expected data first
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		if (!wr) begin
			expQ.push_back(d);
		end
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge clk);
		// held until waitrequest is seen low at an edge
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	// clocks to let pass
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// one-clock trip cause
	task automatic trip();
		faultEvt <= 1'b1;
		@(posedge clk);
		faultEvt <= 1'b0;
		tick(4);
	endtask : trip

	// main sequence
	initial begin
		void'($urandom(84));
		tick(20);
		nrst <= 1'b1;
		tick(3);
		// power-on values, then read-only and unmapped places
		foreach (regA[i]) begin
			bus(1'b0, regA[i], regE[i]);
		end
		bus(1'b1, 5'h0C, 32'hFF);
		bus(1'b1, 5'h1C, 32'hFF);
		bus(1'b0, 5'h0C, 32'h0);
		bus(1'b0, 5'h1C, 32'h0);
		bus(1'b1, 5'h10, 32'h2);
		bus(1'b0, 5'h10, 32'h0);
		// select function on terminal 1
		voltageIn <= 10'($urandom);
		currentIn <= 10'($urandom);
		runCmd <= 1'b1;
		bus(1'b1, 5'h04, {7'h0, 5'h1F, 5'h1F, 5'h1F, 5'h10, 5'h12});
		tick(4);
		bus(1'b0, 5'h18, 32'(voltageIn));
		mdl.set(1, 1'b1);
		tick(15);
		bus(1'b0, 5'h18, 32'(currentIn));
		`CHK(freqRef, currentIn);
		// inverted select swaps back; inverted reset terminal stays inert
		bus(1'b1, 5'h00, 32'h0D);
		tick(15);
		bus(1'b0, 5'h18, 32'(voltageIn));
		`CHK(motorEn, 1'b1);
		mdl.set(1, 1'b0);
		bus(1'b1, 5'h00, 32'h01);
		// select unassigned: sum of both inputs
		bus(1'b1, 5'h04, 32'h1FFFFF2);
		tick(15);
		bus(1'b0, 5'h18, 32'(voltageIn) + 32'(currentIn));
		`CHK(freqRef, 32'(voltageIn) + 32'(currentIn));
		// other sources leave the analog inputs out
		digRef = 11'($urandom);
		bus(1'b1, 5'h08, 32'(digRef));
		for (int s = 0; s < 4; s++) begin
			if (s != 1) begin
				bus(1'b1, 5'h00, 32'(s));
				tick(4);
				bus(1'b0, 5'h18, 32'(digRef));
			end
		end
		bus(1'b1, 5'h00, 32'h01);
		// trip while running, then a full reset pulse; only reset interrupt unmasked
		bus(1'b1, 5'h14, 32'h2);
		trip();
		`CHK(alarmOut, 1'b1);
		`CHK(irq, 1'b0);
		fork
			mdl.hold(0, 30);
			begin
				tick(16);
				`CHK(motorEn, 1'b0);
				`CHK(alarmOut, 1'b0);
				`CHK(pwrResetOut, 1'b1);
			end
		join
		tick(15);
		`CHK(motorEn, 1'b1);
		`CHK(irq, 1'b1);
		bus(1'b0, 5'h10, 32'h3);
		bus(1'b0, 5'h0C, 32'h1);
		bus(1'b1, 5'h10, 32'h3);
		tick(2);
		`CHK(irq, 1'b0);
		// too short a pulse runs no reset
		mdl.hold(0, 10);
		tick(15);
		bus(1'b0, 5'h10, 32'h0);
		// output 0 carries an off delay, output 1 none
		bus(1'b1, 5'h00, 32'h81);
		logicReq <= 3'b011;
		tick(3);
		`CHK(logicOut, 3'b011);
		`CHK(motorEn, 1'b1);
		fork
			mdl.hold(0, 30);
			begin
				while (motorEn !== 1'b0) @(posedge clk);
				`CHK(logicOut, 3'b001);
				`CHK(pwrResetOut, 1'b1);
				tick(12);
				`CHK(logicOut, 3'b000);
			end
		join
		tick(15);
		bus(1'b1, 5'h10, 32'h3);
		bus(1'b1, 5'h00, 32'h01);
		// stop key: inert without alarm, resets with one
		mdl.hold(5, 10);
		tick(15);
		bus(1'b0, 5'h10, 32'h0);
		trip();
		mdl.hold(5, 10);
		tick(15);
		`CHK(alarmOut, 1'b0);
		bus(1'b1, 5'h10, 32'h3);
		// remote plugged in, key window long past
		mdl.set(6, 1'b1);
		trip();
		mdl.hold(5, 10);
		tick(15);
		`CHK(alarmOut, 1'b1);
		mdl.set(6, 1'b0);
		// reset terminal held through a second power-up
		nrst <= 1'b0;
		mdl.set(0, 1'b1);
		tick(20);
		nrst <= 1'b1;
		tick(80);
		`CHK(remoteCommErr, 1'b1);
		`CHK(pwrResetOut, 1'b1);
		bus(1'b0, 5'h0C, 32'h62);
		bus(1'b0, 5'h10, 32'h6);
		mdl.set(0, 1'b0);
		tick(15);
		`CHK(remoteCommErr, 1'b0);
		summarize();
	end
endmodule : tb_top
